// ==== hw/dsfpwm_pkg.sv ====
package dsfpwm_pkg;

  // ==========================================================================
  // Register map, one aligned 32-bit word per register.
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL_A    = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B    = 8'h04;
  localparam logic [7:0] ADDR_COUNTER   = 8'h08;
  localparam logic [7:0] ADDR_COMPARE_A = 8'h0C;
  localparam logic [7:0] ADDR_COMPARE_B = 8'h10;
  localparam logic [7:0] ADDR_CAPTURE   = 8'h14;
  localparam logic [7:0] ADDR_FLAGS     = 8'h18;
  localparam logic [7:0] ADDR_PIN_DIR   = 8'h1C;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int OUT_MODE_A_LSB  = 6;
  localparam int OUT_MODE_B_LSB  = 4;
  localparam int WAVE_LOW_LSB    = 0;
  localparam int WAVE_HIGH_LSB   = 3;
  localparam int PRESCALE_LSB    = 0;
  localparam int FLAG_OVF_BIT    = 0;
  localparam int FLAG_CMP_A_BIT  = 1;
  localparam int FLAG_CMP_B_BIT  = 2;
  localparam int FLAG_CAPT_BIT   = 5;

  // ==========================================================================
  // Mode codes and constants.
  // ==========================================================================
  localparam logic [3:0]  WAVE_PFC_CAPTURE = 4'h8;
  localparam logic [3:0]  WAVE_PFC_COMPARE = 4'h9;
  localparam logic [1:0]  OUT_OFF          = 2'h0;
  localparam logic [1:0]  OUT_TOGGLE       = 2'h1;
  localparam logic [1:0]  OUT_NONINV       = 2'h2;
  localparam logic [1:0]  OUT_INV          = 2'h3;
  localparam logic [15:0] COUNT_BOTTOM     = 16'h0000;
  localparam logic [15:0] REG_RESET16      = 16'h0000;
  localparam logic [7:0]  REG_RESET8       = 8'h00;
  localparam logic [2:0]  PRESCALE_STOP    = 3'h0;

  // Prescaler divide ratios minus one.
  localparam logic [9:0] DIV8_M1    = 10'h007;
  localparam logic [9:0] DIV64_M1   = 10'h03F;
  localparam logic [9:0] DIV256_M1  = 10'h0FF;
  localparam logic [9:0] DIV1024_M1 = 10'h3FF;

  // Direction of the dual-slope counter.
  typedef enum logic {DSF_UP, DSF_DOWN} dsf_dir_type;

  // Compare channel state carried together.
  typedef struct packed {
    logic        match;
    logic        wave;
  } dsf_chan_type;

endpackage

// ==== hw/dsf_prescaler.sv ====
`timescale 1ns/10ps

// Generates the one-cycle timer tick enable from the system clock.
module dsf_prescaler (
  // Clock and reset.
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Divider select, 0 stops the timer.
  input  wire logic [2:0] prescale_sel,
  // Tick enable.
  output logic            timer_tick
);

  logic [9:0] div_count;
  logic [9:0] limit;

  // ==========================================================================
  // Divider
  // ==========================================================================
  // Ratio lookup for select codes 1..5; others stop the timer.
  always_comb begin
    unique case (prescale_sel)
      3'h2:    limit = dsfpwm_pkg::DIV8_M1;
      3'h3:    limit = dsfpwm_pkg::DIV64_M1;
      3'h4:    limit = dsfpwm_pkg::DIV256_M1;
      3'h5:    limit = dsfpwm_pkg::DIV1024_M1;
      default: limit = '0;
    endcase
  end

  // Tick is registered so it is a clean enable, never a clock.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_count  <= '0;
      timer_tick <= 1'b0;
    end else if (prescale_sel == dsfpwm_pkg::PRESCALE_STOP ||
                 prescale_sel > 3'h5) begin
      div_count  <= '0;
      timer_tick <= 1'b0;
    end else if (div_count >= limit) begin
      div_count  <= '0;
      timer_tick <= 1'b1;
    end else begin
      div_count  <= div_count + 10'h001;
      timer_tick <= 1'b0;
    end
  end

endmodule

// ==== hw/dsf_pwm_timer.sv ====
`timescale 1ns/10ps

module dsf_pwm_timer (
  // AHB-Lite clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Waveform pins, a level and a drive enable each.
  output logic             wave_out_a,
  output logic             wave_oe_a,
  output logic             wave_out_b,
  output logic             wave_oe_b
);

  // ==========================================================================
  // Registers and state
  // ==========================================================================
  logic [7:0]  ctrl_a;
  logic [7:0]  ctrl_b;
  logic [15:0] counter_value;
  logic [15:0] compare_buf_a;
  logic [15:0] compare_buf_b;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] capture_value;
  logic        overflow_flag;
  logic        compare_flag_a;
  logic        compare_flag_b;
  logic        capture_flag;
  logic [1:0]  pin_direction_bit;
  logic        wave_a;
  logic        wave_b;
  dsfpwm_pkg::dsf_dir_type direction;

  logic        timer_tick;
  logic [3:0]  waveform_mode_sel;
  logic [1:0]  out_mode_a;
  logic [1:0]  out_mode_b;
  logic        pfc_mode;
  logic [15:0] top_value;
  logic        at_top;
  logic        at_bottom;
  logic        slope_down;
  dsfpwm_pkg::dsf_chan_type chan_a;
  dsfpwm_pkg::dsf_chan_type chan_b;

  // Bus address phase capture.
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        addr_ok;
  logic        wr_now;
  logic [31:0] wdat;

  // Flag write-one-to-clear strobes.
  logic        clr_ovf;
  logic        clr_cmp_a;
  logic        clr_cmp_b;
  logic        clr_capt;

  // ==========================================================================
  // Tick source
  // ==========================================================================
  // The tick stays an enable in this clock domain.
  dsf_prescaler u_prescaler (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .prescale_sel (ctrl_b[dsfpwm_pkg::PRESCALE_LSB +: 3]),
    .timer_tick   (timer_tick)
  );

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  // Mode number is assembled from both control registers.
  assign waveform_mode_sel = {ctrl_b[dsfpwm_pkg::WAVE_HIGH_LSB +: 2],
                              ctrl_a[dsfpwm_pkg::WAVE_LOW_LSB +: 2]};
  assign out_mode_a = ctrl_a[dsfpwm_pkg::OUT_MODE_A_LSB +: 2];
  assign out_mode_b = ctrl_a[dsfpwm_pkg::OUT_MODE_B_LSB +: 2];
  assign pfc_mode   = (waveform_mode_sel == dsfpwm_pkg::WAVE_PFC_CAPTURE) ||
                      (waveform_mode_sel == dsfpwm_pkg::WAVE_PFC_COMPARE);

  // Top comes from the capture register or the active compare A register.
  assign top_value = (waveform_mode_sel == dsfpwm_pkg::WAVE_PFC_COMPARE) ?
                     compare_value_a : capture_value;
  assign at_top    = (counter_value == top_value);
  assign at_bottom = (counter_value == dsfpwm_pkg::COUNT_BOTTOM);

  // A match at top belongs to the falling slope and one at bottom to the
  // rising slope, so in non-inverted mode compare zero stays low and compare top stays high.
  assign slope_down = at_top ||
                      (!at_bottom && direction == dsfpwm_pkg::DSF_DOWN);

  // Compare match against the counter.
  function automatic logic cmp_hit(input logic [15:0] cmp,
                                   input logic [15:0] cnt);
    cmp_hit = (cmp == cnt);
  endfunction

  // Next wave level for one channel on a match.
  function automatic logic wave_next(input logic [1:0] mode,
                                     input logic       cur,
                                     input logic       down,
                                     input logic       tog_ok);
    unique case (mode)
      dsfpwm_pkg::OUT_NONINV: wave_next = down;
      dsfpwm_pkg::OUT_INV:    wave_next = !down;
      dsfpwm_pkg::OUT_TOGGLE: wave_next = tog_ok ? !cur : cur;
      default:                wave_next = cur;
    endcase
  endfunction

  assign chan_a.match = cmp_hit(compare_value_a, counter_value);
  assign chan_b.match = cmp_hit(compare_value_b, counter_value);
  assign chan_a.wave  = wave_next(out_mode_a, wave_a, slope_down,
                                  waveform_mode_sel ==
                                  dsfpwm_pkg::WAVE_PFC_COMPARE);
  assign chan_b.wave  = wave_next(out_mode_b, wave_b, slope_down,
                                  1'b0);

  // ==========================================================================
  // Dual-slope counter
  // ==========================================================================
  // Counter sits on top for one tick, then turns down; writes override.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_value <= dsfpwm_pkg::REG_RESET16;
      direction     <= dsfpwm_pkg::DSF_UP;
    end else if (wr_now && wr_addr == dsfpwm_pkg::ADDR_COUNTER) begin
      counter_value <= wdat[15:0];
    end else if (timer_tick && pfc_mode) begin
      if (direction == dsfpwm_pkg::DSF_UP) begin
        if (at_top) begin
          direction     <= dsfpwm_pkg::DSF_DOWN;
          counter_value <= counter_value - 16'h0001;
        end else begin
          counter_value <= counter_value + 16'h0001;
        end
      end else begin
        if (at_bottom) begin
          direction     <= dsfpwm_pkg::DSF_UP;
          counter_value <= counter_value + 16'h0001;
        end else begin
          counter_value <= counter_value - 16'h0001;
        end
      end
    end
  end

  // ==========================================================================
  // Double-buffered compare values
  // ==========================================================================
  // In the PFC modes loading only at bottom keeps both slopes of a period equal; other modes load every cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_value_a <= dsfpwm_pkg::REG_RESET16;
      compare_value_b <= dsfpwm_pkg::REG_RESET16;
    end else if (!pfc_mode) begin
      compare_value_a <= compare_buf_a;
      compare_value_b <= compare_buf_b;
    end else if (timer_tick && at_bottom) begin
      compare_value_a <= compare_buf_a;
      compare_value_b <= compare_buf_b;
    end
  end

  // ==========================================================================
  // Waveform generation
  // ==========================================================================
  // The level moves only on a match at a tick; the slope signal decides
  // the turning points, which gives the steady low and high cases.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_a <= 1'b0;
      wave_b <= 1'b0;
    end else if (timer_tick && pfc_mode) begin
      if (chan_a.match) begin
        wave_a <= chan_a.wave;
      end
      if (chan_b.match) begin
        wave_b <= chan_b.wave;
      end
    end
  end

  // Pin drive gated by output mode and direction bit; outputs registered.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_out_a <= 1'b0;
      wave_oe_a  <= 1'b0;
      wave_out_b <= 1'b0;
      wave_oe_b  <= 1'b0;
    end else begin
      wave_out_a <= wave_a;
      wave_out_b <= wave_b;
      wave_oe_a  <= (out_mode_a != dsfpwm_pkg::OUT_OFF) &&
                    (out_mode_a != dsfpwm_pkg::OUT_TOGGLE ||
                     waveform_mode_sel == dsfpwm_pkg::WAVE_PFC_COMPARE) &&
                    pin_direction_bit[0];
      wave_oe_b  <= (out_mode_b != dsfpwm_pkg::OUT_OFF) &&
                    (out_mode_b != dsfpwm_pkg::OUT_TOGGLE) &&
                    pin_direction_bit[1];
    end
  end

  // ==========================================================================
  // Flags
  // ==========================================================================
  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag  <= 1'b0;
      compare_flag_a <= 1'b0;
      compare_flag_b <= 1'b0;
      capture_flag   <= 1'b0;
    end else begin
      if (timer_tick && pfc_mode && at_bottom &&
          direction == dsfpwm_pkg::DSF_DOWN) begin
        overflow_flag <= 1'b1;
      end else if (clr_ovf) begin
        overflow_flag <= 1'b0;
      end
      if (timer_tick && pfc_mode && chan_a.match) begin
        compare_flag_a <= 1'b1;
      end else if (clr_cmp_a) begin
        compare_flag_a <= 1'b0;
      end
      if (timer_tick && pfc_mode && chan_b.match) begin
        compare_flag_b <= 1'b1;
      end else if (clr_cmp_b) begin
        compare_flag_b <= 1'b0;
      end
      if (timer_tick && pfc_mode && at_top &&
          waveform_mode_sel == dsfpwm_pkg::WAVE_PFC_CAPTURE) begin
        capture_flag <= 1'b1;
      end else if (clr_capt) begin
        capture_flag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // AHB-Lite slave
  // ==========================================================================
  assign addr_ok = hsel && hready && htrans[1];
  assign wr_now  = wr_pend;
  assign wdat    = hwdata;
  assign clr_ovf   = wr_now && wr_addr == dsfpwm_pkg::ADDR_FLAGS &&
                     wdat[dsfpwm_pkg::FLAG_OVF_BIT];
  assign clr_cmp_a = wr_now && wr_addr == dsfpwm_pkg::ADDR_FLAGS &&
                     wdat[dsfpwm_pkg::FLAG_CMP_A_BIT];
  assign clr_cmp_b = wr_now && wr_addr == dsfpwm_pkg::ADDR_FLAGS &&
                     wdat[dsfpwm_pkg::FLAG_CMP_B_BIT];
  assign clr_capt  = wr_now && wr_addr == dsfpwm_pkg::ADDR_FLAGS &&
                     wdat[dsfpwm_pkg::FLAG_CAPT_BIT];

  // Address phase is latched; the slave never inserts wait states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= dsfpwm_pkg::REG_RESET8;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= addr_ok && hwrite;
      wr_addr   <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Register writes in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a            <= dsfpwm_pkg::REG_RESET8;
      ctrl_b            <= dsfpwm_pkg::REG_RESET8;
      compare_buf_a     <= dsfpwm_pkg::REG_RESET16;
      compare_buf_b     <= dsfpwm_pkg::REG_RESET16;
      capture_value     <= dsfpwm_pkg::REG_RESET16;
      pin_direction_bit <= 2'h0;
    end else if (wr_now) begin
      unique case (wr_addr)
        dsfpwm_pkg::ADDR_CTRL_A:    ctrl_a        <= wdat[7:0];
        dsfpwm_pkg::ADDR_CTRL_B:    ctrl_b        <= wdat[7:0];
        dsfpwm_pkg::ADDR_COMPARE_A: compare_buf_a <= wdat[15:0];
        dsfpwm_pkg::ADDR_COMPARE_B: compare_buf_b <= wdat[15:0];
        dsfpwm_pkg::ADDR_CAPTURE:   capture_value <= wdat[15:0];
        dsfpwm_pkg::ADDR_PIN_DIR:   pin_direction_bit <= wdat[1:0];
        default: ;
      endcase
    end
  end

  // Read data is registered a cycle early so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        dsfpwm_pkg::ADDR_CTRL_A:    hrdata <= {24'h0, ctrl_a};
        dsfpwm_pkg::ADDR_CTRL_B:    hrdata <= {24'h0, ctrl_b};
        dsfpwm_pkg::ADDR_COUNTER:   hrdata <= {16'h0, counter_value};
        dsfpwm_pkg::ADDR_COMPARE_A: hrdata <= {16'h0, compare_buf_a};
        dsfpwm_pkg::ADDR_COMPARE_B: hrdata <= {16'h0, compare_buf_b};
        dsfpwm_pkg::ADDR_CAPTURE:   hrdata <= {16'h0, capture_value};
        dsfpwm_pkg::ADDR_FLAGS:     hrdata <= {26'h0, capture_flag, 2'h0,
                                               compare_flag_b,
                                               compare_flag_a,
                                               overflow_flag};
        dsfpwm_pkg::ADDR_PIN_DIR:   hrdata <= {30'h0, pin_direction_bit};
        default:                    hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Counter turning points, buffer loads and flags.
  chk_top_hold_once: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer_tick && pfc_mode && at_top && direction == dsfpwm_pkg::DSF_UP &&
    !wr_now |=> direction == dsfpwm_pkg::DSF_DOWN)
    else $error("Counter did not turn down after top.");

  chk_buffer_load_bottom: assert property (
    @(posedge hclk) disable iff (!hresetn)
    pfc_mode && $changed(compare_value_a) && $past(pfc_mode) |->
    $past(timer_tick) && $past(at_bottom))
    else $error("Compare A loaded away from bottom.");

  chk_ovf_with_load: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer_tick && pfc_mode && at_bottom &&
    direction == dsfpwm_pkg::DSF_DOWN |=> overflow_flag)
    else $error("Overflow flag missing at bottom.");

  chk_cmp_flag_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer_tick && pfc_mode && chan_a.match |=> compare_flag_a)
    else $error("Compare A flag missing on match.");

  chk_capt_flag_top: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer_tick && at_top &&
    waveform_mode_sel == dsfpwm_pkg::WAVE_PFC_CAPTURE |=> capture_flag)
    else $error("Capture flag missing at top.");

  // A match at a turning point belongs to the slope that follows it.
  chk_noninv_up_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer_tick && pfc_mode && chan_a.match && !at_top &&
    out_mode_a == dsfpwm_pkg::OUT_NONINV &&
    direction == dsfpwm_pkg::DSF_UP |=> !wave_a ##1 !wave_out_a)
    else $error("Non-inverted output not cleared on up match.");

  chk_inv_down_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer_tick && pfc_mode && chan_a.match && !at_bottom &&
    out_mode_a == dsfpwm_pkg::OUT_INV &&
    direction == dsfpwm_pkg::DSF_DOWN |=> !wave_a)
    else $error("Inverted output not cleared on down match.");

  chk_top_match_high: assert property (
    @(posedge hclk) disable iff (!hresetn)
    timer_tick && pfc_mode && chan_a.match && at_top &&
    out_mode_a == dsfpwm_pkg::OUT_NONINV |=> wave_a)
    else $error("Non-inverted output not set on a top match.");

  chk_pin_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (out_mode_a == dsfpwm_pkg::OUT_OFF || !pin_direction_bit[0]) |=>
    !wave_oe_a)
    else $error("Pin A driven while disconnected.");

  chk_no_tick_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !timer_tick && !wr_now |=> $stable(counter_value))
    else $error("Counter moved without a tick.");

endmodule

// ==== verification/dsfpwm_load_model.sv ====
`timescale 1ns/10ps

// =====
// Load on one waveform pin with a pull-up that wins while released.
module dsfpwm_load_model (
  // Clock.
  input  wire logic        hclk,
  // Pin drive from the timer.
  input  wire logic        wave_out,
  input  wire logic        wave_oe,
  // Window control and count of high cycles.
  input  wire logic        measure,
  output logic [15:0]      high_count
);
  logic pin_level;

  // A released pin reads high, so a stray level leaks into the count.
  assign pin_level = wave_oe ? wave_out : 1'b1;

  // Count high cycles while the window is open; closing it restarts.
  always_ff @(posedge hclk) begin
    if (!measure) begin
      high_count <= 16'h0000;
    end else if (pin_level === 1'b1) begin
      high_count <= high_count + 16'h0001;
    end
  end
endmodule

// ==== verification/tb_dual_slope_freq_correct_pwm.sv ====
`timescale 1ns/10ps

// =====
// Bench for the dual-slope PWM timer, channels A and B each into a pin load.
module tb_dual_slope_freq_correct_pwm;
  typedef struct packed {
    logic [2:0]  ps;
    logic [1:0]  low;
    logic [1:0]  om;
    logic        dir;
    logic [15:0] cmp;
    logic [15:0] exp;
    logic [15:0] win;
  } dsfpwm_row_type;

  logic           hclk = 1'b0;
  logic           hresetn = 1'b0;
  logic [31:0]    haddr = 32'h00000000;
  logic [1:0]     htrans = 2'h0;
  logic           hwrite = 1'b0;
  logic [31:0]    hwdata = 32'h00000000;
  logic [31:0]    hrdata;
  logic           hreadyout;
  logic           hresp;
  logic           wave_out_a;
  logic           wave_oe_a;
  logic           wave_out_b;
  logic           wave_oe_b;
  logic           measure = 1'b0;
  logic [15:0]    high_count;
  logic [15:0]    high_count_b;
  logic [31:0]    rd;
  int             fail_count = 0;
  int             checks = 0;
  dsfpwm_row_type rows[9];

  // Free-running system clock.
  always #5 hclk = ~hclk;

  dsf_pwm_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wave_out_a(wave_out_a),
    .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b));

  dsfpwm_load_model load_a (.hclk(hclk), .wave_out(wave_out_a),
    .wave_oe(wave_oe_a), .measure(measure), .high_count(high_count));

  dsfpwm_load_model load_b (.hclk(hclk), .wave_out(wave_out_b),
    .wave_oe(wave_oe_b), .measure(measure), .high_count(high_count_b));

  // =====
  // Bus tasks: each phase is held until hready is seen high.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic cmp32(input string w, input logic [31:0] e,
                       input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic rdc(input string w, input logic [7:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    cmp32(w, e, rd);
  endtask

  task automatic tally_and_finish();
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hang costs a mismatch; the runs need about 3500 cycles.
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    tally_and_finish();
  end

  // =====
  // Main sequence. Top is 8, so one period is 16 ticks.
  initial begin
    rows = '{
      '{3'h1, 2'h0, 2'h2, 1'b1, 16'h0003, 16'h0018, 16'h0040},
      '{3'h1, 2'h0, 2'h3, 1'b1, 16'h0003, 16'h0028, 16'h0040},
      '{3'h1, 2'h0, 2'h2, 1'b1, 16'h0000, 16'h0000, 16'h0040},
      '{3'h1, 2'h0, 2'h2, 1'b1, 16'h0008, 16'h0040, 16'h0040},
      '{3'h1, 2'h0, 2'h3, 1'b1, 16'h0000, 16'h0040, 16'h0040},
      '{3'h1, 2'h1, 2'h1, 1'b1, 16'h0008, 16'h0020, 16'h0040},
      '{3'h1, 2'h0, 2'h0, 1'b1, 16'h0003, 16'h0040, 16'h0040},
      '{3'h1, 2'h0, 2'h2, 1'b0, 16'h0003, 16'h0040, 16'h0040},
      '{3'h2, 2'h0, 2'h2, 1'b1, 16'h0003, 16'h00C0, 16'h0200}
    };
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("ctrl_a", dsfpwm_pkg::ADDR_CTRL_A, 32'h00000000);
    rdc("counter", dsfpwm_pkg::ADDR_COUNTER, 32'h00000000);
    wr(dsfpwm_pkg::ADDR_CAPTURE, 32'h00000008);
    // Settle one window, then count high cycles over four periods.
    foreach (rows[i]) begin
      wr(dsfpwm_pkg::ADDR_COMPARE_A, {16'h0000, rows[i].cmp});
      wr(dsfpwm_pkg::ADDR_PIN_DIR, {30'h0, {2{rows[i].dir}}});
      wr(dsfpwm_pkg::ADDR_CTRL_A, {24'h0, rows[i].om, 4'h0, rows[i].low});
      wr(dsfpwm_pkg::ADDR_CTRL_B, {27'h0, 2'h2, rows[i].ps});
      repeat (rows[i].win) @(posedge hclk);
      measure <= 1'b1;
      repeat (rows[i].win) @(posedge hclk);
      measure <= 1'b0;
      // The count is settled by the falling edge; the bus restarts on a rise.
      @(negedge hclk);
      cmp32("high_count", 32'(rows[i].exp), 32'(high_count));
      @(posedge hclk);
    end
    // Running flags come back after a clear; B matches at the bottom.
    wr(dsfpwm_pkg::ADDR_FLAGS, 32'h00000027);
    repeat (300) @(posedge hclk);
    rdc("flags", dsfpwm_pkg::ADDR_FLAGS, 32'h00000027);
    // Channel B non-inverted, compare 5 of top 8: high 10 ticks of 16.
    wr(dsfpwm_pkg::ADDR_COMPARE_B, 32'h00000005);
    wr(dsfpwm_pkg::ADDR_CTRL_A, 32'h000000A0);
    repeat (256) @(posedge hclk);
    measure <= 1'b1;
    repeat (512) @(posedge hclk);
    measure <= 1'b0;
    @(negedge hclk);
    cmp32("high_count_b", 32'h00000140, 32'(high_count_b));
    @(posedge hclk);
    // With the tick stopped nothing moves, not even the flags.
    wr(dsfpwm_pkg::ADDR_CTRL_B, 32'h00000010);
    wr(dsfpwm_pkg::ADDR_FLAGS, 32'h00000027);
    wr(dsfpwm_pkg::ADDR_COUNTER, 32'h00000005);
    repeat (100) @(posedge hclk);
    rdc("counter", dsfpwm_pkg::ADDR_COUNTER, 32'h00000005);
    rdc("flags", dsfpwm_pkg::ADDR_FLAGS, 32'h00000000);
    // An unmapped word ignores writes and reads zero.
    wr(8'h40, 32'hFFFFFFFF);
    rdc("unmapped", 8'h40, 32'h00000000);
    cmp32("hresp", 32'h00000000, {31'h0, hresp});
    tally_and_finish();
  end
endmodule
